// [design/wdc_pkg.sv]
// constants shared by the windowed watchdog sleep and clear logic
package wdc_pkg;
	// register offsets (byte addresses, one aligned word each)
	localparam logic [7:0] WDC_CTRL_OFS = 8'h00;
	localparam logic [7:0] WDC_PERIOD_OFS = 8'h04;
	localparam logic [7:0] WDC_COUNT_OFS = 8'h08;
	localparam logic [7:0] WDC_PWRCTL_OFS = 8'h0c;
	localparam logic [7:0] WDC_IRQ_STAT_OFS = 8'h10;
	localparam logic [7:0] WDC_IRQ_MASK_OFS = 8'h14;

	// control register field positions
	localparam int WDC_CTRL_MODE_LSB = 0;
	localparam int WDC_CTRL_SWEN_BIT = 2;
	localparam int WDC_CTRL_STARTUP_BIT = 3;
	localparam int WDC_CTRL_XTAL_BIT = 4;
	localparam int WDC_CTRL_DIV_LSB = 5;

	// power control register field positions
	localparam int WDC_PWR_TIMEOUT_BIT = 0;
	localparam int WDC_PWR_POWERDOWN_BIT = 1;
	localparam int WDC_PWR_RST_BIT = 2;

	// interrupt status bits
	localparam int WDC_IRQ_WAKE_BIT = 0;
	localparam int WDC_IRQ_RESET_BIT = 1;

	// widths
	localparam int WDC_CNT_W = 16;
	localparam int WDC_DIV_W = 3;
	localparam int WDC_IRQ_W = 2;

	// reset values
	localparam logic [WDC_CNT_W-1:0] WDC_PERIOD_RST = 16'hffff;
	localparam logic [WDC_DIV_W-1:0] WDC_DIV_RST = 3'h0;
	localparam logic [WDC_IRQ_W-1:0] WDC_IRQ_RST = 2'h0;

	// watchdog enable mode encodings
	typedef enum logic [1:0] {
		WDC_MODE_OFF = 2'b00,
		WDC_MODE_SW = 2'b01,
		WDC_MODE_AWAKE = 2'b10,
		WDC_MODE_ON = 2'b11
	} wdc_mode_e;
	localparam wdc_mode_e WDC_MODE_RST = WDC_MODE_OFF;
endpackage

// [design/wdc_counter.sv]
// window watchdog counter with synchronous clear and expiry pulse
`timescale 1ns/1ns
module wdc_counter (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// control
	input wire logic clr,
	input wire logic run,
	input wire logic [wdc_pkg::WDC_CNT_W-1:0] limit,
	// state
	output logic [wdc_pkg::WDC_CNT_W-1:0] count,
	output logic expire
);
	logic [wdc_pkg::WDC_CNT_W-1:0] cnt_q;
	logic [wdc_pkg::WDC_CNT_W-1:0] cnt_d;
	logic exp_q;
	logic exp_d;

	// clear beats counting; reaching the limit wraps to zero and fires once
	always_comb begin
		cnt_d = cnt_q;
		exp_d = 1'b0;
		if (clr) begin
			cnt_d = '0;
		end else if (run) begin
			if (cnt_q == limit) begin
				cnt_d = '0;
				exp_d = 1'b1;
			end else begin
				cnt_d = cnt_q + 16'h0001;
			end
		end
	end

	// state registers
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			cnt_q <= '0;
			exp_q <= 1'b0;
		end else begin
			cnt_q <= cnt_d;
			exp_q <= exp_d;
		end
	end

	assign count = cnt_q;
	assign expire = exp_q;
endmodule

// [design/wdc_sleep_ctl.sv]
// windowed watchdog top: sleep handling, clearing, flags, registers and interrupt
`timescale 1ns/1ns
// Summary of operation
// - Each entry into sleep clears the watchdog counter to zero.
// - If the enable mode keeps the watchdog on in sleep, it counts on from zero while asleep.
// - Each exit from sleep clears the watchdog counter to zero again.
// - With the oscillator start-up timer enabled in a crystal mode, the counter stays clear after wake until the timer is done.
// - A time-out while asleep gives no reset but wakes the device instead.
// - A time-out wake updates the active-low time-out and power-down flags, and the reset flag is readable.
// - In the awake-only mode sleep entry clears the counter, and the clear instruction always clears it.
// - Changing the oscillator divider selection leaves the counter untouched.
module wdc_sleep_ctl (
	// clock and reset
	input wire logic MCLK,
	input wire logic SYS_RST,
	// core status
	input wire logic SLEEP,
	input wire logic CLEAR_WATCHDOG_INSTR,
	// oscillator start-up timer done, asynchronous
	input wire logic OSC_STARTUP_TIMER_DONE,
	// register port
	input wire logic [7:0] ADDR,
	input wire logic [31:0] WR_DATA,
	input wire logic WR_EN,
	input wire logic RD_EN,
	output logic [31:0] RD_DATA,
	// results
	output logic WDT_RESET,
	output logic WAKE,
	output logic IRQ
);
	// configuration and status state
	wdc_pkg::wdc_mode_e mode_q, mode_d;
	logic software_enable_bit_q, software_enable_bit_d;
	logic osc_startup_timer_en_q, osc_startup_timer_en_d;
	logic xtal_q, xtal_d;
	logic [wdc_pkg::WDC_DIV_W-1:0] div_q, div_d;
	logic [wdc_pkg::WDC_CNT_W-1:0] period_q, period_d;
	logic timeout_flag_n_q, timeout_flag_n_d;
	logic powerdown_flag_n_q, powerdown_flag_n_d;
	logic rst_flag_q, rst_flag_d;
	logic [wdc_pkg::WDC_IRQ_W-1:0] irq_stat_q, irq_stat_d;
	logic [wdc_pkg::WDC_IRQ_W-1:0] irq_mask_q, irq_mask_d;
	logic [31:0] rd_q, rd_d;
	// sleep sequencing state
	logic sleep_q;
	logic hold_q, hold_d;
	logic reset_q, reset_d;
	logic wake_q, wake_d;
	// synchroniser for the start-up timer done level
	logic startup_meta_q;
	logic startup_done_q;
	// derived
	logic sleep_enter;
	logic sleep_exit;
	logic active;
	logic cnt_clr;
	logic [wdc_pkg::WDC_CNT_W-1:0] count;
	logic expire;
	logic sleep_tmo;
	logic awake_tmo;
	logic wr_ctrl, wr_period, wr_pwr, wr_stat, wr_mask;

	// sleep edges seen against the registered level
	assign sleep_enter = SLEEP && !sleep_q;
	assign sleep_exit = !SLEEP && sleep_q;

	// whether the counter may run now; the awake-only mode stops in sleep
	always_comb begin
		active = 1'b0;
		unique case (mode_q)
			wdc_pkg::WDC_MODE_OFF: active = 1'b0;
			wdc_pkg::WDC_MODE_SW: active = software_enable_bit_q;
			wdc_pkg::WDC_MODE_AWAKE: active = !SLEEP;
			wdc_pkg::WDC_MODE_ON: active = 1'b1;
		endcase
	end

	// every clearing cause folded into one synchronous clear
	assign cnt_clr = sleep_enter
		|| sleep_exit
		|| CLEAR_WATCHDOG_INSTR
		|| hold_q
		|| !active;

	wdc_counter u_counter (
		.clk(MCLK),
		.rst(SYS_RST),
		.clr(cnt_clr),
		.run(active),
		.limit(period_q),
		.count(count),
		.expire(expire)
	);

	// expiry is judged against the sleep state it was counted in
	assign sleep_tmo = expire && sleep_q;
	assign awake_tmo = expire && !sleep_q;

	// register write decode
	assign wr_ctrl = WR_EN && (ADDR == wdc_pkg::WDC_CTRL_OFS);
	assign wr_period = WR_EN && (ADDR == wdc_pkg::WDC_PERIOD_OFS);
	assign wr_pwr = WR_EN && (ADDR == wdc_pkg::WDC_PWRCTL_OFS);
	assign wr_stat = WR_EN && (ADDR == wdc_pkg::WDC_IRQ_STAT_OFS);
	assign wr_mask = WR_EN && (ADDR == wdc_pkg::WDC_IRQ_MASK_OFS);

	// configuration registers; the divider field feeds nothing in the counter
	always_comb begin
		mode_d = mode_q;
		software_enable_bit_d = software_enable_bit_q;
		osc_startup_timer_en_d = osc_startup_timer_en_q;
		xtal_d = xtal_q;
		div_d = div_q;
		period_d = period_q;
		irq_mask_d = irq_mask_q;
		if (wr_ctrl) begin
			mode_d = wdc_pkg::wdc_mode_e'(WR_DATA[wdc_pkg::WDC_CTRL_MODE_LSB +: 2]);
			software_enable_bit_d = WR_DATA[wdc_pkg::WDC_CTRL_SWEN_BIT];
			osc_startup_timer_en_d = WR_DATA[wdc_pkg::WDC_CTRL_STARTUP_BIT];
			xtal_d = WR_DATA[wdc_pkg::WDC_CTRL_XTAL_BIT];
			div_d = WR_DATA[wdc_pkg::WDC_CTRL_DIV_LSB +: wdc_pkg::WDC_DIV_W];
		end
		if (wr_period) begin
			period_d = WR_DATA[wdc_pkg::WDC_CNT_W-1:0];
		end
		if (wr_mask) begin
			irq_mask_d = WR_DATA[wdc_pkg::WDC_IRQ_W-1:0];
		end
	end

	// start-up hold: armed at wake in crystal modes, released by the synced done level
	always_comb begin
		hold_d = hold_q;
		if (sleep_exit && osc_startup_timer_en_q && xtal_q) begin
			hold_d = 1'b1;
		end else if (startup_done_q) begin
			hold_d = 1'b0;
		end
	end

	// reset request or wake, never both for one expiry
	always_comb begin
		reset_d = awake_tmo;
		wake_d = sleep_tmo;
	end

	// flags: hardware events win over software writes in the same cycle
	always_comb begin
		timeout_flag_n_d = timeout_flag_n_q;
		powerdown_flag_n_d = powerdown_flag_n_q;
		rst_flag_d = rst_flag_q;
		if (wr_pwr && WR_DATA[wdc_pkg::WDC_PWR_RST_BIT]) begin
			rst_flag_d = 1'b0;
		end
		if (CLEAR_WATCHDOG_INSTR) begin
			timeout_flag_n_d = 1'b1;
			powerdown_flag_n_d = 1'b1;
		end
		if (sleep_enter) begin
			timeout_flag_n_d = 1'b1;
			powerdown_flag_n_d = 1'b0;
		end
		if (sleep_tmo) begin
			timeout_flag_n_d = 1'b0;
			powerdown_flag_n_d = 1'b0;
		end
		if (awake_tmo) begin
			timeout_flag_n_d = 1'b0;
			powerdown_flag_n_d = 1'b1;
			rst_flag_d = 1'b1;
		end
	end

	// sticky interrupt status, write one to clear, set wins
	always_comb begin
		irq_stat_d = irq_stat_q;
		if (wr_stat) begin
			irq_stat_d = irq_stat_q & ~WR_DATA[wdc_pkg::WDC_IRQ_W-1:0];
		end
		if (sleep_tmo) begin
			irq_stat_d[wdc_pkg::WDC_IRQ_WAKE_BIT] = 1'b1;
		end
		if (awake_tmo) begin
			irq_stat_d[wdc_pkg::WDC_IRQ_RESET_BIT] = 1'b1;
		end
	end

	// read mux; unmapped offsets answer zero
	always_comb begin
		rd_d = rd_q;
		if (RD_EN) begin
			rd_d = 32'h0000_0000;
			unique case (ADDR)
				wdc_pkg::WDC_CTRL_OFS: begin
					rd_d[wdc_pkg::WDC_CTRL_MODE_LSB +: 2] = mode_q;
					rd_d[wdc_pkg::WDC_CTRL_SWEN_BIT] = software_enable_bit_q;
					rd_d[wdc_pkg::WDC_CTRL_STARTUP_BIT] = osc_startup_timer_en_q;
					rd_d[wdc_pkg::WDC_CTRL_XTAL_BIT] = xtal_q;
					rd_d[wdc_pkg::WDC_CTRL_DIV_LSB +: wdc_pkg::WDC_DIV_W] = div_q;
				end
				wdc_pkg::WDC_PERIOD_OFS: rd_d[wdc_pkg::WDC_CNT_W-1:0] = period_q;
				wdc_pkg::WDC_COUNT_OFS: rd_d[wdc_pkg::WDC_CNT_W-1:0] = count;
				wdc_pkg::WDC_PWRCTL_OFS: begin
					rd_d[wdc_pkg::WDC_PWR_TIMEOUT_BIT] = timeout_flag_n_q;
					rd_d[wdc_pkg::WDC_PWR_POWERDOWN_BIT] = powerdown_flag_n_q;
					rd_d[wdc_pkg::WDC_PWR_RST_BIT] = rst_flag_q;
				end
				wdc_pkg::WDC_IRQ_STAT_OFS: rd_d[wdc_pkg::WDC_IRQ_W-1:0] = irq_stat_q;
				wdc_pkg::WDC_IRQ_MASK_OFS: rd_d[wdc_pkg::WDC_IRQ_W-1:0] = irq_mask_q;
				default: rd_d = 32'h0000_0000;
			endcase
		end
	end

	// all state registers; the done input passes two flops before use
	always_ff @(posedge MCLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			mode_q <= wdc_pkg::WDC_MODE_RST;
			software_enable_bit_q <= 1'b0;
			osc_startup_timer_en_q <= 1'b0;
			xtal_q <= 1'b0;
			div_q <= wdc_pkg::WDC_DIV_RST;
			period_q <= wdc_pkg::WDC_PERIOD_RST;
			timeout_flag_n_q <= 1'b1;
			powerdown_flag_n_q <= 1'b1;
			rst_flag_q <= 1'b0;
			irq_stat_q <= wdc_pkg::WDC_IRQ_RST;
			irq_mask_q <= wdc_pkg::WDC_IRQ_RST;
			rd_q <= 32'h0000_0000;
			sleep_q <= 1'b0;
			hold_q <= 1'b0;
			reset_q <= 1'b0;
			wake_q <= 1'b0;
			startup_meta_q <= 1'b0;
			startup_done_q <= 1'b0;
		end else begin
			mode_q <= mode_d;
			software_enable_bit_q <= software_enable_bit_d;
			osc_startup_timer_en_q <= osc_startup_timer_en_d;
			xtal_q <= xtal_d;
			div_q <= div_d;
			period_q <= period_d;
			timeout_flag_n_q <= timeout_flag_n_d;
			powerdown_flag_n_q <= powerdown_flag_n_d;
			rst_flag_q <= rst_flag_d;
			irq_stat_q <= irq_stat_d;
			irq_mask_q <= irq_mask_d;
			rd_q <= rd_d;
			sleep_q <= SLEEP;
			hold_q <= hold_d;
			reset_q <= reset_d;
			wake_q <= wake_d;
			startup_meta_q <= OSC_STARTUP_TIMER_DONE;
			startup_done_q <= startup_meta_q;
		end
	end

	// outputs
	assign RD_DATA = rd_q;
	assign WDT_RESET = reset_q;
	assign WAKE = wake_q;
	assign IRQ = |(irq_stat_q & irq_mask_q);

	// checks on the sleep and clear behaviour
	property p_enter_clear;
		@(posedge MCLK) disable iff (SYS_RST)
		sleep_enter |=> (count == '0);
	endproperty
	a_enter_clear: assert property (p_enter_clear) else $error("count not cleared at sleep entry");

	property p_sleep_count;
		@(posedge MCLK) disable iff (SYS_RST)
		(SLEEP && sleep_q && active && !cnt_clr && count != period_q) |=>
			(count == $past(count) + 16'h0001);
	endproperty
	a_sleep_count: assert property (p_sleep_count) else $error("counter stalled during sleep");

	property p_exit_clear;
		@(posedge MCLK) disable iff (SYS_RST)
		sleep_exit |=> (count == '0);
	endproperty
	a_exit_clear: assert property (p_exit_clear) else $error("count not cleared at sleep exit");

	property p_ost_hold;
		@(posedge MCLK) disable iff (SYS_RST)
		(sleep_exit && osc_startup_timer_en_q && xtal_q) |=>
			(hold_q && count == '0) ##1 (count == '0);
	endproperty
	a_ost_hold: assert property (p_ost_hold) else $error("counter ran before start-up done");

	property p_sleep_no_reset;
		@(posedge MCLK) disable iff (SYS_RST)
		sleep_tmo |=> (WAKE && !WDT_RESET);
	endproperty
	a_sleep_no_reset: assert property (p_sleep_no_reset) else $error("sleep time-out misbehaved");

	property p_sleep_flags;
		@(posedge MCLK) disable iff (SYS_RST)
		sleep_tmo |=> (!timeout_flag_n_q && !powerdown_flag_n_q
			&& irq_stat_q[wdc_pkg::WDC_IRQ_WAKE_BIT]);
	endproperty
	a_sleep_flags: assert property (p_sleep_flags) else $error("wake flags not updated");

	property p_clear_instr;
		@(posedge MCLK) disable iff (SYS_RST)
		CLEAR_WATCHDOG_INSTR |=> (count == '0 && timeout_flag_n_q && powerdown_flag_n_q);
	endproperty
	a_clear_instr: assert property (p_clear_instr) else $error("clear instruction did not clear");

	property p_div_keep;
		@(posedge MCLK) disable iff (SYS_RST)
		(wr_ctrl && WR_DATA[wdc_pkg::WDC_CTRL_MODE_LSB +: 5] ==
			{xtal_q, osc_startup_timer_en_q, software_enable_bit_q, mode_q}
			&& active && !cnt_clr && count != period_q) |=> (count == $past(count) + 16'h0001);
	endproperty
	a_div_keep: assert property (p_div_keep) else $error("divider write disturbed count");

	property p_disabled;
		@(posedge MCLK) disable iff (SYS_RST)
		(!active && $past(!active)) |-> (count == '0 && !expire);
	endproperty
	a_disabled: assert property (p_disabled) else $error("disabled watchdog counted");

	property p_awake_reset;
		@(posedge MCLK) disable iff (SYS_RST)
		awake_tmo |=> (WDT_RESET && !WAKE && rst_flag_q);
	endproperty
	a_awake_reset: assert property (p_awake_reset) else $error("awake time-out gave no reset");
endmodule

// [bench/tb_wdc_sleep_ctl.sv]
// self-checking bench for the windowed watchdog sleep and clear logic
`timescale 1ns/1ns
module tb_wdc_sleep_ctl;
	localparam logic [7:0] CTL = wdc_pkg::WDC_CTRL_OFS;
	localparam logic [7:0] PER = wdc_pkg::WDC_PERIOD_OFS;
	localparam logic [7:0] CNT = wdc_pkg::WDC_COUNT_OFS;
	localparam logic [7:0] PWR = wdc_pkg::WDC_PWRCTL_OFS;
	localparam logic [7:0] STA = wdc_pkg::WDC_IRQ_STAT_OFS;
	localparam logic [7:0] MSK = wdc_pkg::WDC_IRQ_MASK_OFS;
	localparam int P = 3;
	logic mclk = 1'b0;
	logic sys_rst = 1'b1;
	logic sleep = 1'b0;
	logic clr = 1'b0;
	logic startup_done = 1'b0;
	logic [7:0] addr = 8'h00;
	logic [31:0] wr_data = 32'h0;
	logic wr_en = 1'b0;
	logic rd_en = 1'b0;
	logic [31:0] rd_data;
	logic wdt_reset;
	logic wake;
	logic irq;
	logic [31:0] v;
	logic [31:0] w;
	int bad_count = 0;
	int checks = 0;
	int cyc = 0;
	int n;

	wdc_sleep_ctl u_dut (
		.MCLK(mclk),
		.SYS_RST(sys_rst),
		.SLEEP(sleep),
		.CLEAR_WATCHDOG_INSTR(clr),
		.OSC_STARTUP_TIMER_DONE(startup_done),
		.ADDR(addr),
		.WR_DATA(wr_data),
		.WR_EN(wr_en),
		.RD_EN(rd_en),
		.RD_DATA(rd_data),
		.WDT_RESET(wdt_reset),
		.WAKE(wake),
		.IRQ(irq)
	);

	// 125 MHz clock
	always #4 mclk = ~mclk;

	// hang guard, far above the 150-odd cycles the run needs
	always @(posedge mclk) begin
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			bad_count = bad_count + 1;
			test_done();
		end
	end

	task automatic test_done();
		$display("checks %0d mismatches %0d", checks, bad_count);
		if (bad_count == 0 && checks > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checks = checks + 1;
		if (seen !== exp) begin
			bad_count = bad_count + 1;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	// one-cycle write; the #1 lets register updates land before any look
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge mclk);
		addr <= a;
		wr_data <= d;
		wr_en <= 1'b1;
		@(posedge mclk);
		wr_en <= 1'b0;
		#1;
	endtask

	// read data appear the cycle after the strobe and hold until the next read
	task automatic rd(input logic [7:0] a);
		@(posedge mclk);
		addr <= a;
		rd_en <= 1'b1;
		@(posedge mclk);
		rd_en <= 1'b0;
		#1 v = rd_data;
	endtask

	task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
		rd(a);
		chk(v, exp);
	endtask

	// counts edges until the chosen pulse shows, bounded
	task automatic wait_pulse(input bit sel);
		n = 0;
		while ((sel ? wake : wdt_reset) !== 1'b1 && n < 50) begin
			@(posedge mclk);
			#1 n = n + 1;
		end
	endtask

	task automatic t_reset();
		rdc(CTL, 32'h0);
		rdc(PER, 32'hffff);
		rdc(CNT, 32'h0);
		rdc(PWR, 32'h3);
		rdc(STA, 32'h0);
		rdc(MSK, 32'h0);
		rdc(8'h18, 32'h0);
		chk(32'(irq), 32'h0);
	endtask

	task automatic t_off_awake();
		wr(PER, P);
		repeat (10) @(posedge mclk);
		rdc(CNT, 32'h0);
		wr(CTL, 32'h1);
		repeat (10) @(posedge mclk);
		rdc(CNT, 32'h0);
		wr(CTL, 32'h5);
		wait_pulse(1'b0);
		chk(n, P + 2);
		wr(CTL, 32'h0);
		rdc(PWR, 32'h6);
		rdc(STA, 32'h2);
		chk(32'(irq), 32'h0);
		wr(MSK, 32'h2);
		chk(32'(irq), 32'h1);
		wr(STA, 32'h2);
		chk(32'(irq), 32'h0);
		wr(PWR, 32'h4);
		rdc(PWR, 32'h2);
	endtask

	// time-out in sleep wakes with no reset request
	task automatic t_sleep_timeout();
		wr(MSK, 32'h1);
		@(posedge mclk) sleep <= 1'b1;
		wr(CTL, 32'h3);
		wait_pulse(1'b1);
		chk(n, P + 2);
		wr(PER, 32'hffff);
		rdc(PWR, 32'h0);
		rdc(STA, 32'h1);
		chk(32'(irq), 32'h1);
	endtask

	task automatic t_sleep_edges();
		@(posedge mclk) sleep <= 1'b0;
		rdc(CNT, 32'h0);
		rdc(CNT, 32'h2);
		@(posedge mclk) sleep <= 1'b1;
		rdc(CNT, 32'h0);
		rdc(CNT, 32'h2);
		rdc(PWR, 32'h1);
		@(posedge mclk) sleep <= 1'b0;
	endtask

	task automatic t_clear();
		@(posedge mclk) clr <= 1'b1;
		@(posedge mclk) clr <= 1'b0;
		#1;
		rdc(CNT, 32'h1);
		rdc(PWR, 32'h3);
		rd(CNT);
		w = v;
		wr(CTL, 32'he3);
		rdc(CNT, w + 32'h4);
		rdc(CTL, 32'he3);
		wr(CTL, 32'h2);
		@(posedge mclk) sleep <= 1'b1;
		rdc(CNT, 32'h0);
		rdc(CNT, 32'h0);
		@(posedge mclk) sleep <= 1'b0;
		// awake-only mode clears at exit and then counts again
		rdc(CNT, 32'h0);
		rdc(CNT, 32'h2);
	endtask

	// crystal wake waits for the start-up timer before counting
	task automatic t_startup();
		wr(CTL, 32'h1b);
		@(posedge mclk) sleep <= 1'b1;
		repeat (4) @(posedge mclk);
		sleep <= 1'b0;
		repeat (10) @(posedge mclk);
		rdc(CNT, 32'h0);
		@(posedge mclk) startup_done <= 1'b1;
		repeat (8) @(posedge mclk);
		rd(CNT);
		// two sync edges, hold drop, then six counting edges up to the read
		chk(v, 32'h6);
	endtask

	initial begin
		repeat (5) @(posedge mclk);
		sys_rst <= 1'b0;
		t_reset();
		t_off_awake();
		t_sleep_timeout();
		t_sleep_edges();
		t_clear();
		t_startup();
		test_done();
	end
endmodule
